//--- rtl/sfp_device.sv
// Device end of the synchronous slave FIFO port with 32 socket buffers.
//
// Behaviour
// - Addressed socket shows on flags three cycles later.
// - First read word appears exactly two cycles later.
// - Flags reflect a write three cycles later.
// - Master waits 68 cycles after switching.
// - SDR clock at most 100 MHz, one edge.
// - DDR write needs clock from 100 to 160.
// - Packet end without data commits empty packet.
// - Data bus driven only while output enable active.
// - Narrow link 0 control line order fixed.
// - Narrow 0 8-bit: address above data lanes.
// - Narrow 0 16-bit: address on control 9, 8.
// - Endpoint switch pin with 5-bit addressing, at 8 bits or on the wide link.
// - Narrow link 1 uses upper lanes, lines 10-18.
// - Wide link has four flags, lines 5 to 8.
// - Wide link address sits above data lanes, and on control 19 down to 15 at 32 bits.
`timescale 1ns/1ps
module sfp_device
  import sfp_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Link pins
  sfp_link_if.device link,
  // Static link configuration
  input wire sfp_cfg_t cfg,
  // Low power and endpoint switch
  input wire logic low_power_entry,
  output logic endpoint_switch,
  // Packet commit events
  output logic commit_valid,
  output logic [SOCK_AW-1:0] commit_socket,
  output logic [LEN_W-1:0] commit_length,
  output logic commit_zero_length_packet,
  // Fill level of the socket last addressed
  output logic [CNT_W-1:0] socket_level
);

  // The master is logic on this same clock, so its pins are sampled directly.
  wire logic [PIN_W-1:0] pins_in = {link.control_line, link.dq};

  wire logic cs_act = !pins_in[sfp_stb_pin(cfg, STB_CS)];
  wire logic wr_act = cs_act && !pins_in[sfp_stb_pin(cfg, STB_WR)];
  wire logic rd_act = cs_act && !pins_in[sfp_stb_pin(cfg, STB_RD)];
  wire logic pe_act = cs_act && !pins_in[sfp_stb_pin(cfg, STB_PE)];
  wire logic oe_act = cs_act && !pins_in[sfp_stb_pin(cfg, STB_OE)];
  wire logic [SOCK_AW-1:0] addr_in = sfp_get_addr(cfg, pins_in);
  wire logic [DQ_W-1:0] word_in = sfp_get_word(cfg, pins_in);
  wire logic eps_in = sfp_eps_used(cfg) && !pins_in[sfp_eps_pin(cfg)];

  // Sample stage.
  logic s0_wr;
  logic s0_rd;
  logic s0_pe;
  logic [SOCK_AW-1:0] s0_addr;
  logic [DQ_W-1:0] s0_word;
  // Flag pipeline.
  logic [SOCK_AW-1:0] s1_addr;
  logic [3:0] flag_q1;
  logic [3:0] flag_out;
  // Read data pipeline.
  logic [DQ_W-1:0] rd_word;
  logic [DQ_W-1:0] data_out;
  // Socket state.
  logic [DQ_W-1:0] mem [SOCK_N][DEPTH];
  logic [PTR_W-1:0] wr_ptr [SOCK_N];
  logic [PTR_W-1:0] rd_ptr [SOCK_N];
  logic [CNT_W-1:0] cnt [SOCK_N];
  logic [LEN_W-1:0] pkt_len [SOCK_N];

  // Flag meaning per bit: 0 space left, 1 data present, 2 almost full, 3 almost empty.
  function automatic logic [3:0] sock_status(logic [CNT_W-1:0] n);
    return {n <= CNT_W'(ALMOST_EMPTY), n >= CNT_W'(ALMOST_FULL), n != '0, n != CNT_W'(DEPTH)};
  endfunction

  wire logic [CNT_W-1:0] cur_cnt = cnt[s0_addr];
  wire logic [LEN_W-1:0] cur_len = pkt_len[s0_addr];
  // A write to a full socket and a read from an empty one are dropped.
  wire logic do_wr = s0_wr && cur_cnt != CNT_W'(DEPTH);
  wire logic do_rd = s0_rd && cur_cnt != '0;
  wire logic [CNT_W-1:0] next_cnt = cur_cnt + CNT_W'(do_wr) - CNT_W'(do_rd);
  wire logic [LEN_W-1:0] next_commit_len = cur_len + LEN_W'(do_wr);
  wire logic [LEN_W-1:0] next_len = s0_pe ? '0 : next_commit_len;
  wire logic [DQ_W-1:0] dq_mask = sfp_data_mask(cfg);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s0_wr <= 1'b0;
      s0_rd <= 1'b0;
      s0_pe <= 1'b0;
      s0_addr <= '0;
      s0_word <= '0;
      endpoint_switch <= 1'b0;
    end else begin
      s0_wr <= wr_act;
      s0_rd <= rd_act;
      s0_pe <= pe_act;
      s0_addr <= addr_in;
      s0_word <= word_in;
      endpoint_switch <= eps_in;
    end
  end

  // Flags trail the sample edge by three edges, for both address and write.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s1_addr <= '0;
      flag_q1 <= 4'h0;
      flag_out <= 4'h0;
    end else begin
      s1_addr <= s0_addr;
      flag_q1 <= sock_status(cnt[s1_addr]);
      flag_out <= flag_q1;
    end
  end

  // Read word is fetched one edge after sampling and launched on the next.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rd_word <= '0;
      data_out <= '0;
    end else begin
      if (do_rd) begin
        rd_word <= mem[s0_addr][rd_ptr[s0_addr]];
      end
      data_out <= rd_word;
    end
  end

  always_ff @(posedge clock) begin
    if (do_wr) begin
      mem[s0_addr][wr_ptr[s0_addr]] <= s0_word;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < SOCK_N; i++) begin
        wr_ptr[i] <= '0;
        rd_ptr[i] <= '0;
        cnt[i] <= '0;
        pkt_len[i] <= '0;
      end
    end else begin
      if (do_wr) begin
        wr_ptr[s0_addr] <= wr_ptr[s0_addr] + PTR_W'(1);
      end
      if (do_rd) begin
        rd_ptr[s0_addr] <= rd_ptr[s0_addr] + PTR_W'(1);
      end
      cnt[s0_addr] <= next_cnt;
      pkt_len[s0_addr] <= next_len;
    end
  end

  // A packet end with no word in the same cycle or since the socket's last packet end closes an empty packet.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      commit_valid <= 1'b0;
      commit_socket <= '0;
      commit_length <= '0;
      commit_zero_length_packet <= 1'b0;
      socket_level <= '0;
    end else begin
      commit_valid <= s0_pe;
      commit_socket <= s0_addr;
      commit_length <= next_commit_len;
      commit_zero_length_packet <= s0_pe && next_commit_len == '0;
      socket_level <= next_cnt;
    end
  end

  // Pin drive. Data lanes follow output enable without a clock so the bus
  // turns round in the same cycle the master lets go of it.
  logic [PIN_W-1:0] pin_out;
  logic [PIN_W-1:0] pin_oe_n;

  always_comb begin
    pin_out = '0;
    pin_oe_n = '1;
    pin_out[DQ_W-1:0] = sfp_put_word(cfg, data_out);
    pin_oe_n[DQ_W-1:0] = ~(dq_mask & {DQ_W{oe_act}});
    for (int f = 0; f < sfp_flag_n(cfg); f++) begin
      pin_out[sfp_flag_pin(cfg, f)] = flag_out[f];
      pin_oe_n[sfp_flag_pin(cfg, f)] = 1'b0;
    end
    pin_out[sfp_lpe_pin(cfg)] = low_power_entry;
    pin_oe_n[sfp_lpe_pin(cfg)] = 1'b0;
  end

  assign link.dq_dev_out = pin_out[DQ_W-1:0];
  assign link.dq_dev_oe_n = pin_oe_n[DQ_W-1:0];
  assign link.ctl_dev_out = pin_out[PIN_W-1:CTL_OFS];
  assign link.ctl_dev_oe_n = pin_oe_n[PIN_W-1:CTL_OFS];

endmodule

//--- rtl/sfp_pkg.sv
// Shared constants, types and pin mapping functions for the slave FIFO port.
package sfp_pkg;
  localparam int DQ_W = 32;
  localparam int CTL_W = 20;
  localparam int PIN_W = 52;
  localparam int CTL_OFS = 32;
  localparam int SOCK_N = 32;
  localparam int SOCK_AW = 5;
  localparam int DEPTH = 8;
  localparam int PTR_W = 3;
  localparam int CNT_W = 4;
  localparam int LEN_W = 8;
  localparam int ADDR_N_SHORT = 2;
  localparam int ADDR_N_LONG = 5;
  localparam int STB_CS = 0;
  localparam int STB_WR = 1;
  localparam int STB_OE = 2;
  localparam int STB_RD = 3;
  localparam int STB_PE = 4;
  localparam int N1_CTL_BASE = 10;
  localparam int N1_DQ_BASE = 16;
  localparam int ADDR_TOP_N0 = 9;
  localparam int ADDR_TOP_HI = 19;
  localparam int FLAG_A_N0 = 5;
  localparam int FLAG_B_N0 = 6;
  localparam int FLAG_A_N1 = 16;
  localparam int FLAG_B_N1 = 15;
  localparam int FLAG_A_WIDE = 8;
  localparam int LPE_N0 = 7;
  localparam int LPE_N1 = 17;
  localparam int LPE_WIDE = 9;
  localparam int EPS_N0 = 8;
  localparam int EPS_N1 = 18;
  localparam int EPS_WIDE = 10;
  localparam int ALMOST_FULL = 6;
  localparam int ALMOST_EMPTY = 1;
  localparam int LAT_ACCD = 2;
  localparam int LAT_FAD = 3;
  localparam int LAT_ADDR = 3;
  localparam int SSD_MIN = 2;
  localparam int SSD_MAX = 68;
  localparam int SDR_MAX_MHZ = 100;
  localparam int DDR_MIN_MHZ = 100;
  localparam int DDR_MAX_MHZ = 160;
  localparam int CLOCK_MHZ = 40;
  localparam int MST_RD_PIPE = LAT_ACCD + 2;

  typedef enum logic [1:0] {SFP_NARROW0, SFP_NARROW1, SFP_WIDE} sfp_link_t;
  typedef enum logic [1:0] {SFP_W8, SFP_W16, SFP_W24, SFP_W32} sfp_width_t;
  typedef enum logic [1:0] {SFP_OP_WRITE, SFP_OP_WRITE_END, SFP_OP_READ, SFP_OP_PKT_END} sfp_op_t;
  typedef struct packed {
    sfp_link_t link;
    sfp_width_t width;
    logic addr5;
  } sfp_cfg_t;

  function automatic int sfp_bits(sfp_cfg_t c);
    return (int'(c.width) + 1) * 8;
  endfunction

  function automatic int sfp_dq_base(sfp_cfg_t c);
    return (c.link == SFP_NARROW1) ? N1_DQ_BASE : 0;
  endfunction

  function automatic int sfp_stb_pin(sfp_cfg_t c, int s);
    return CTL_OFS + ((c.link == SFP_NARROW1) ? N1_CTL_BASE : 0) + s;
  endfunction

  function automatic int sfp_addr_n(sfp_cfg_t c);
    return c.addr5 ? ADDR_N_LONG : ADDR_N_SHORT;
  endfunction

  function automatic int sfp_addr_pin(sfp_cfg_t c, int i);
    logic on_ctl;
    on_ctl = (c.link != SFP_WIDE && c.width == SFP_W16) || c.width == SFP_W32;
    if (on_ctl) begin
      return CTL_OFS + ((c.link == SFP_NARROW0) ? ADDR_TOP_N0 : ADDR_TOP_HI) - i;
    end
    return sfp_dq_base(c) + sfp_bits(c) + i;
  endfunction

  function automatic int sfp_flag_n(sfp_cfg_t c);
    return (c.link == SFP_WIDE) ? 4 : 2;
  endfunction

  function automatic int sfp_flag_pin(sfp_cfg_t c, int f);
    unique case (c.link)
      SFP_NARROW0: return CTL_OFS + ((f == 0) ? FLAG_A_N0 : FLAG_B_N0);
      SFP_NARROW1: return CTL_OFS + ((f == 0) ? FLAG_A_N1 : FLAG_B_N1);
      default: return CTL_OFS + FLAG_A_WIDE - f;
    endcase
  endfunction

  function automatic int sfp_lpe_pin(sfp_cfg_t c);
    return CTL_OFS + ((c.link == SFP_NARROW0) ? LPE_N0 : (c.link == SFP_NARROW1) ? LPE_N1 : LPE_WIDE);
  endfunction

  function automatic int sfp_eps_pin(sfp_cfg_t c);
    return CTL_OFS + ((c.link == SFP_NARROW0) ? EPS_N0 : (c.link == SFP_NARROW1) ? EPS_N1 : EPS_WIDE);
  endfunction

  function automatic logic sfp_eps_used(sfp_cfg_t c);
    return c.addr5 && (c.width == SFP_W8 || c.link == SFP_WIDE);
  endfunction

  function automatic logic [SOCK_AW-1:0] sfp_get_addr(sfp_cfg_t c, logic [PIN_W-1:0] p);
    logic [SOCK_AW-1:0] a;
    a = '0;
    for (int i = 0; i < sfp_addr_n(c); i++) begin
      a[i] = p[sfp_addr_pin(c, i)];
    end
    return a;
  endfunction

  function automatic logic [DQ_W-1:0] sfp_get_word(sfp_cfg_t c, logic [PIN_W-1:0] p);
    logic [DQ_W-1:0] w;
    w = '0;
    for (int i = 0; i < sfp_bits(c); i++) begin
      w[i] = p[sfp_dq_base(c) + i];
    end
    return w;
  endfunction

  function automatic logic [DQ_W-1:0] sfp_put_word(sfp_cfg_t c, logic [DQ_W-1:0] w);
    logic [DQ_W-1:0] p;
    p = '0;
    for (int i = 0; i < sfp_bits(c); i++) begin
      p[sfp_dq_base(c) + i] = w[i];
    end
    return p;
  endfunction

  function automatic logic [DQ_W-1:0] sfp_data_mask(sfp_cfg_t c);
    return sfp_put_word(c, '1);
  endfunction
endpackage

//--- rtl/sfp_link_if.sv
// Pins of the slave FIFO link between the device and its master.
`timescale 1ns/1ps
interface sfp_link_if;
  logic [31:0] dq_dev_out;
  logic [31:0] dq_dev_oe_n;
  logic [31:0] dq_mst_out;
  logic [31:0] dq_mst_oe_n;
  logic [19:0] ctl_dev_out;
  logic [19:0] ctl_dev_oe_n;
  logic [19:0] ctl_mst_out;
  logic [19:0] ctl_mst_oe_n;
  logic [31:0] dq;
  logic [19:0] control_line;

  // Undriven lines float high, as with weak pull-ups on the board.
  assign dq = (~dq_dev_oe_n & dq_dev_out) | (~dq_mst_oe_n & dq_mst_out) | (dq_dev_oe_n & dq_mst_oe_n);
  assign control_line = (~ctl_dev_oe_n & ctl_dev_out) | (~ctl_mst_oe_n & ctl_mst_out) |
    (ctl_dev_oe_n & ctl_mst_oe_n);

  modport device (
    input dq,
    input control_line,
    output dq_dev_out,
    output dq_dev_oe_n,
    output ctl_dev_out,
    output ctl_dev_oe_n
  );

  modport master (
    input dq,
    input control_line,
    output dq_mst_out,
    output dq_mst_oe_n,
    output ctl_mst_out,
    output ctl_mst_oe_n
  );
endinterface

//--- rtl/sfp_master.sv
// Master end of the synchronous slave FIFO port, as an FPGA would drive it.
`timescale 1ns/1ps
module sfp_master
  import sfp_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Link pins
  sfp_link_if.master link,
  // Static link configuration
  input wire sfp_cfg_t cfg,
  // Command port
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire sfp_op_t cmd_op,
  input wire logic [SOCK_AW-1:0] cmd_socket,
  input wire logic [DQ_W-1:0] cmd_word,
  // Read data
  output logic rd_valid,
  output logic [DQ_W-1:0] rd_data,
  // Device status
  output logic [3:0] flags,
  output logic low_power_entry,
  // Endpoint switch request
  input wire logic endpoint_switch
);

  typedef enum logic {M_IDLE, M_SWITCH} sfp_mst_state_t;

  sfp_mst_state_t state;
  logic [6:0] wait_cnt;
  logic [SOCK_AW-1:0] cur_socket;
  logic cs_n;
  logic wr_n;
  logic rd_n;
  logic pe_n;
  logic drive_data;
  logic [DQ_W-1:0] out_word;
  logic [MST_RD_PIPE-1:0] rd_pipe;

  wire logic [PIN_W-1:0] pins_in = {link.control_line, link.dq};
  wire logic op_wr = cmd_op == SFP_OP_WRITE || cmd_op == SFP_OP_WRITE_END;
  wire logic op_pe = cmd_op == SFP_OP_WRITE_END || cmd_op == SFP_OP_PKT_END;
  wire logic op_rd = cmd_op == SFP_OP_READ;
  wire logic reads_busy = rd_pipe != '0;
  // Writes wait until every read word is home, since the data lanes turn round.
  assign cmd_ready = state == M_IDLE && cmd_valid && cmd_socket == cur_socket && !(op_wr && reads_busy);
  wire logic need_switch = state == M_IDLE && cmd_valid && cmd_socket != cur_socket && !reads_busy;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state <= M_IDLE;
      wait_cnt <= '0;
      cur_socket <= '0;
    end else begin
      unique case (state)
        M_IDLE: begin
          if (need_switch) begin
            cur_socket <= cmd_socket;
            wait_cnt <= 7'(SSD_MAX - 1);
            state <= M_SWITCH;
          end
        end
        M_SWITCH: begin
          wait_cnt <= wait_cnt - 7'h01;
          if (wait_cnt == '0) begin
            state <= M_IDLE;
          end
        end
      endcase
    end
  end

  // Each accepted command drives its write, read or packet end strobe for exactly one cycle.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cs_n <= 1'b1;
      wr_n <= 1'b1;
      rd_n <= 1'b1;
      pe_n <= 1'b1;
      drive_data <= 1'b0;
      out_word <= '0;
      rd_pipe <= '0;
    end else begin
      cs_n <= 1'b0;
      wr_n <= !(cmd_ready && op_wr);
      rd_n <= !(cmd_ready && op_rd);
      pe_n <= !(cmd_ready && op_pe);
      drive_data <= cmd_ready ? op_wr : drive_data && !reads_busy;
      if (cmd_ready && op_wr) begin
        out_word <= cmd_word;
      end
      rd_pipe <= {rd_pipe[MST_RD_PIPE-2:0], cmd_ready && op_rd};
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rd_valid <= 1'b0;
      rd_data <= '0;
      flags <= 4'h0;
      low_power_entry <= 1'b0;
    end else begin
      rd_valid <= rd_pipe[MST_RD_PIPE-1];
      if (rd_pipe[MST_RD_PIPE-1]) begin
        rd_data <= sfp_get_word(cfg, pins_in);
      end
      for (int f = 0; f < 4; f++) begin
        flags[f] <= (f < sfp_flag_n(cfg)) ? pins_in[sfp_flag_pin(cfg, f)] : 1'b0;
      end
      low_power_entry <= pins_in[sfp_lpe_pin(cfg)];
    end
  end

  logic [PIN_W-1:0] pin_out;
  logic [PIN_W-1:0] pin_oe_n;

  always_comb begin
    pin_out = '0;
    pin_oe_n = '1;
    pin_out[DQ_W-1:0] = sfp_put_word(cfg, out_word);
    pin_oe_n[DQ_W-1:0] = ~(sfp_data_mask(cfg) & {DQ_W{drive_data}});
    pin_out[sfp_stb_pin(cfg, STB_CS)] = cs_n;
    pin_out[sfp_stb_pin(cfg, STB_WR)] = wr_n;
    pin_out[sfp_stb_pin(cfg, STB_OE)] = drive_data;
    pin_out[sfp_stb_pin(cfg, STB_RD)] = rd_n;
    pin_out[sfp_stb_pin(cfg, STB_PE)] = pe_n;
    for (int s = STB_CS; s <= STB_PE; s++) begin
      pin_oe_n[sfp_stb_pin(cfg, s)] = 1'b0;
    end
    for (int i = 0; i < sfp_addr_n(cfg); i++) begin
      pin_out[sfp_addr_pin(cfg, i)] = cur_socket[i];
      pin_oe_n[sfp_addr_pin(cfg, i)] = 1'b0;
    end
    if (sfp_eps_used(cfg)) begin
      pin_out[sfp_eps_pin(cfg)] = !endpoint_switch;
      pin_oe_n[sfp_eps_pin(cfg)] = 1'b0;
    end
  end

  assign link.dq_mst_out = pin_out[DQ_W-1:0];
  assign link.dq_mst_oe_n = pin_oe_n[DQ_W-1:0];
  assign link.ctl_mst_out = pin_out[PIN_W-1:CTL_OFS];
  assign link.ctl_mst_oe_n = pin_oe_n[PIN_W-1:CTL_OFS];

endmodule

//--- verif/sfp_link_assertions.sv
// Concurrent checks on the slave FIFO link pins between the device and the master.
`timescale 1ns/1ps
module sfp_link_assertions
  import sfp_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Link configuration
  input wire sfp_cfg_t cfg,
  // Link pins
  input wire logic [31:0] dq_dev_out,
  input wire logic [31:0] dq_dev_oe_n,
  input wire logic [31:0] dq_mst_oe_n,
  input wire logic [19:0] ctl_dev_oe_n,
  input wire logic [19:0] ctl_mst_oe_n,
  input wire logic [19:0] control_line,
  input wire logic [31:0] dq
);
  logic [3:0] age;
  logic [4:0] addr_q;
  logic [6:0] since_sw;
  wire wide = cfg.link == SFP_WIDE;
  wire n1 = cfg.link == SFP_NARROW1;
  // Narrow link 1 carries its strobes ten lines further up.
  wire [4:0] sb = n1 ? 5'h0A : 5'h00;
  wire sel = !control_line[sb];
  wire oe_off = control_line[sb + 5'h02];
  wire wr_go = sel && !control_line[sb + 5'h01];
  wire rd_go = sel && !control_line[sb + 5'h03];
  wire pe_go = sel && !control_line[sb + 5'h04];
  wire [4:0] addr = wide ? {control_line[15], control_line[16], control_line[17], control_line[18],
    control_line[19]} : n1 ? dq[28:24] : {3'h0, control_line[8], control_line[9]};
  wire addr_chg = addr != addr_q;
  wire [3:0] flag_pins = wide ? control_line[8:5] : n1 ? {2'h0, control_line[16:15]} :
    {2'h0, control_line[6:5]};
  wire flag_cause = wr_go || rd_go || pe_go || addr_chg;

  // Flags settle from their reset level without a cause, so the age counter masks that start.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      age <= 4'h0;
      addr_q <= 5'h00;
      since_sw <= 7'h7F;
    end else begin
      age <= (age == 4'hF) ? age : age + 4'h1;
      addr_q <= addr;
      since_sw <= addr_chg ? 7'h00 : (since_sw == 7'h7F) ? since_sw : since_sw + 7'h01;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  sequence s_read_taken;
    rd_go && !oe_off;
  endsequence
  sequence s_strobe_taken;
    wr_go || rd_go || pe_go;
  endsequence

  a_bus_release: assert property (oe_off |-> &dq_dev_oe_n)
    else $error("data bus driven with output enable off");
  a_read_drive: assert property (s_read_taken |-> !(&dq_dev_oe_n))
    else $error("data bus not driven during read");
  a_drive_needs_cs: assert property (!(&dq_dev_oe_n) |-> sel && !oe_off)
    else $error("data bus driven without select and enable");
  a_no_contention: assert property ((~dq_dev_oe_n & ~dq_mst_oe_n) == 32'h0)
    else $error("both ends drive the data bus");
  a_read_latency: assert property ($changed(dq_dev_out) |-> $past(rd_go, 3))
    else $error("read data moved without a read two edges before");
  a_flag_latency: assert property ($changed(flag_pins) && age == 4'hF |-> $past(flag_cause, 4))
    else $error("flags moved without a cause three edges before");
  a_flag_owner: assert property (wide ? ctl_dev_oe_n[9:5] == 5'h00 : n1 ? ctl_dev_oe_n[17:15] == 3'h0 :
    ctl_dev_oe_n[7:5] == 3'h0)
    else $error("flag lines not driven by the device");
  a_strobe_owner: assert property (ctl_dev_oe_n[sb +: 5] == 5'h1F && ctl_mst_oe_n[sb +: 5] == 5'h00)
    else $error("strobe lines owned by the wrong end");
  a_addr_owner: assert property (wide ? ctl_mst_oe_n[19:15] == 5'h00 : n1 ? dq_mst_oe_n[28:24] == 5'h00 :
    ctl_mst_oe_n[9:8] == 2'h0)
    else $error("address lines not driven by the master");
  // The bound keeps two edges of slack for where the switch edge is counted.
  a_switch_wait: assert property (s_strobe_taken |-> since_sw >= SSD_MAX - 2)
    else $error("strobe too soon after socket switch");
  a_write_oe_off: assert property (wr_go |-> oe_off)
    else $error("output enable active during write");
endmodule

//--- verif/tb.sv
// Testbench joining the device and master ends of the slave FIFO port.
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, (g), (e)); end end
module tb;
  import sfp_pkg::*;
  typedef struct {int cyc; logic [DQ_W-1:0] v;} sfp_exp_t;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  sfp_cfg_t cfg = '{SFP_NARROW0, SFP_W16, 1'b0};
  logic cmd_valid = 1'b0;
  sfp_op_t cmd_op = SFP_OP_WRITE;
  logic [SOCK_AW-1:0] cmd_socket = '0;
  logic [DQ_W-1:0] cmd_word = '0;
  logic lpe_in = 1'b0;
  logic eps_req = 1'b0;
  logic cmd_ready, rd_valid, eps_out, commit_valid, commit_zlp, mst_lpe;
  logic [DQ_W-1:0] rd_data;
  logic [3:0] flags;
  logic [SOCK_AW-1:0] commit_socket;
  logic [LEN_W-1:0] commit_length;
  logic [CNT_W-1:0] socket_level;
  int mismatches = 0;
  int checks = 0;
  int cyc = 0;
  int cur = 0;
  int plen = 0;
  logic [31:0] seed = 32'h2C73;
  logic [DQ_W-1:0] fifo [SOCK_N][$];
  sfp_exp_t rd_q[$];
  sfp_exp_t cm_q[$];

  sfp_link_if lk();
  sfp_device sfp_device_inst (.clock(clock), .rst_b(rst_b), .link(lk.device), .cfg(cfg),
    .low_power_entry(lpe_in), .endpoint_switch(eps_out), .commit_valid(commit_valid),
    .commit_socket(commit_socket), .commit_length(commit_length), .commit_zero_length_packet(commit_zlp),
    .socket_level(socket_level));
  sfp_master sfp_master_inst (.clock(clock), .rst_b(rst_b), .link(lk.master), .cfg(cfg),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_socket(cmd_socket),
    .cmd_word(cmd_word), .rd_valid(rd_valid), .rd_data(rd_data), .flags(flags),
    .low_power_entry(mst_lpe), .endpoint_switch(eps_req));
  sfp_link_assertions sfp_link_assertions_inst (.clock(clock), .rst_b(rst_b), .cfg(cfg),
    .dq_dev_out(lk.dq_dev_out), .dq_dev_oe_n(lk.dq_dev_oe_n), .dq_mst_oe_n(lk.dq_mst_oe_n),
    .ctl_dev_oe_n(lk.ctl_dev_oe_n), .ctl_mst_oe_n(lk.ctl_mst_oe_n), .control_line(lk.control_line),
    .dq(lk.dq));

  always #(500.0 / CLOCK_MHZ) clock = ~clock;

  function automatic logic [31:0] next_rand(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // The whole run needs well under a thousand edges.
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      $display("unexpected at %0t: timeout", $time);
      stop_test();
    end
  end

  task automatic take(ref sfp_exp_t q[$], input logic [DQ_W-1:0] got);
    `CHK(q.size() > 0, 1'b1)
    if (q.size() > 0) begin
      `CHK(cyc, q[0].cyc)
      `CHK(got, q[0].v)
      void'(q.pop_front());
    end
  endtask

  // Sampled on the falling edge so registered outputs have settled.
  always @(negedge clock) begin
    if (rd_valid === 1'b1) begin
      take(rd_q, rd_data);
    end
    if (commit_valid === 1'b1) begin
      take(cm_q, {commit_zlp, commit_length, commit_socket});
    end
  end

  task automatic cmd(input sfp_op_t op, input int s, input logic [DQ_W-1:0] w);
    int n;
    logic [DQ_W-1:0] m;
    sfp_exp_t e;
    n = 0;
    m = w & ~(32'hFFFFFFFF << (8 * (int'(cfg.width) + 1)));
    cmd_op = op;
    cmd_socket = s[SOCK_AW-1:0];
    cmd_word = w;
    cmd_valid = 1'b1;
    // Ready is judged on the edge itself, so a stale value from the last command cannot fake an accept.
    @(posedge clock);
    while (cmd_ready !== 1'b1 && n < 200) begin
      @(posedge clock);
      n++;
    end
    #1;
    e.cyc = cyc;
    `CHK(n < 200, 1'b1)
    if (s != cur) `CHK(n >= SSD_MAX, 1'b1)
    cur = s;
    if (op == SFP_OP_READ) begin
      e.cyc += MST_RD_PIPE;
      e.v = fifo[s].pop_front();
      rd_q.push_back(e);
    end else begin
      if (op != SFP_OP_PKT_END) begin
        fifo[s].push_back(m);
        plen++;
      end
      if (op != SFP_OP_WRITE) begin
        // The commit leaves the device on the edge after its sample edge, two edges before the flags.
        e.cyc += LAT_FAD - 1;
        e.v = {plen == 0, plen[7:0], s[4:0]};
        cm_q.push_back(e);
        plen = 0;
      end
    end
  endtask

  task automatic idle_chk(input string name);
    int lvl;
    logic [3:0] f;
    cmd_valid = 1'b0;
    repeat (8) @(posedge clock);
    #1;
    lvl = fifo[cur].size();
    f = {cfg.link == SFP_WIDE && lvl <= ALMOST_EMPTY, cfg.link == SFP_WIDE && lvl >= ALMOST_FULL, lvl > 0,
      lvl < DEPTH};
    `CHK(socket_level, CNT_W'(lvl))
    `CHK(flags, f)
    `CHK(rd_q.size() + cm_q.size(), 0)
    $display("test %s done", name);
  endtask

  task automatic run_cfg(input sfp_cfg_t c, input int far);
    logic [4:0] ap;
    rst_b = 1'b0;
    cfg = c;
    foreach (fifo[i]) fifo[i].delete();
    cur = 0;
    plen = 0;
    repeat (6) @(posedge clock);
    #1;
    rst_b = 1'b1;
    idle_chk("reset");
    for (int i = 0; i < DEPTH; i++) begin
      seed = next_rand(seed);
      cmd(i == DEPTH - 1 ? SFP_OP_WRITE_END : SFP_OP_WRITE, 0, seed);
    end
    idle_chk("fill");
    repeat (DEPTH) cmd(SFP_OP_READ, 0, '0);
    idle_chk("drain");
    cmd(SFP_OP_PKT_END, 0, '0);
    cmd(SFP_OP_WRITE, 0, seed);
    cmd(SFP_OP_PKT_END, 0, '0);
    idle_chk("packet end");
    cmd(SFP_OP_WRITE_END, far, ~seed);
    idle_chk("switch");
    ap = (c.link == SFP_WIDE) ? {lk.control_line[15], lk.control_line[16], lk.control_line[17],
      lk.control_line[18], lk.control_line[19]} : (c.link == SFP_NARROW1) ? lk.dq[28:24] :
      {3'h0, lk.control_line[8], lk.control_line[9]};
    `CHK(ap, far[4:0])
    cmd(SFP_OP_READ, far, '0);
    cmd(SFP_OP_READ, 0, '0);
    idle_chk("return");
    lpe_in = 1'b1;
    eps_req = 1'b1;
    repeat (3) @(posedge clock);
    #1;
    `CHK(mst_lpe, 1'b1)
    `CHK(lk.control_line[c.link == SFP_WIDE ? 9 : c.link == SFP_NARROW1 ? 17 : 7], 1'b1)
    `CHK(lk.control_line[c.link == SFP_NARROW1 ? 18 : 10], !c.addr5)
    `CHK(eps_out, c.addr5)
    lpe_in = 1'b0;
    eps_req = 1'b0;
    repeat (3) @(posedge clock);
    #1;
    `CHK(mst_lpe, 1'b0)
    `CHK(eps_out, 1'b0)
    $display("test pins done");
  endtask

  initial begin
    `CHK(CLOCK_MHZ <= SDR_MAX_MHZ, 1'b1)
    // Only SDR transfers are built, so the clock must stay below the DDR write range.
    `CHK(CLOCK_MHZ < DDR_MIN_MHZ, 1'b1)
    run_cfg('{SFP_NARROW0, SFP_W16, 1'b0}, 3);
    run_cfg('{SFP_WIDE, SFP_W32, 1'b1}, SOCK_N - 1);
    run_cfg('{SFP_NARROW1, SFP_W8, 1'b1}, 17);
    stop_test();
  end
endmodule
